// ---- ifp_core.sv ----
`timescale 1ns/1ps
`include "ifp_defines.svh"

module ifp_core (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // oscillator ticks, synchronous to clk
  input  wire logic                   osc_sel,
  input  wire logic                   fast_internal_oscillator_tick,
  input  wire logic                   slow_internal_oscillator_tick,
  // register port
  input  wire logic [`IFP_RADDR_W-1:0] reg_addr,
  input  wire logic [`IFP_LOW_W-1:0]   reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`IFP_LOW_W-1:0]   reg_rdata,
  // program memory
  output logic      [`IFP_PC_W-1:0]    pmem_addr,
  output logic                        pmem_rd,
  input  wire logic [`IFP_INSTR_W-1:0] pmem_data,
  // decode and execute datapath
  output logic      [3:0]             instruction_phases,
  output logic                        cycle_start,
  output logic      [`IFP_INSTR_W-1:0] exec_instr,
  output logic                        exec_valid,
  input  ifp_pkg::ifp_alu_op_e         alu_op,
  input  wire logic                   alu_en,
  input  wire logic [`IFP_ALU_W-1:0]   alu_operand,
  input  wire logic                   ex_jump,
  input  wire logic [`IFP_PC_W-1:0]    ex_target,
  input  wire logic                   ex_skip,
  output logic      [`IFP_ALU_W-1:0]   acc_value,
  output logic                        alu_carry,
  output logic                        alu_zero,
  output logic      [`IFP_PC_W-1:0]    pc_value
);

  ifp_pkg::ifp_core_s  q, d;
  ifp_pkg::ifp_phase_e phase;
  logic                advance;
  logic                boundary;
  logic                alu_step;
  logic                low_wr_hit;
  logic                low_rd_hit;
  logic                take_jump;
  logic                flush;
  logic [`IFP_PC_W-1:0] base;
  logic [`IFP_ALU_W-1:0] alu_res;
  logic                alu_c;
  logic                alu_z;

  ifp_phase_gen u_phase (
    .clk                           (clk),
    .sys_rst                       (sys_rst),
    .osc_sel                       (osc_sel),
    .fast_internal_oscillator_tick (fast_internal_oscillator_tick),
    .slow_internal_oscillator_tick (slow_internal_oscillator_tick),
    .phase                         (phase),
    .advance                       (advance)
  );

  ifp_alu u_alu (
    .op        (alu_op),
    .acc       (q.acc),
    .operand   (alu_operand),
    .carry_in  (q.carry),
    .result    (alu_res),
    .carry_out (alu_c),
    .zero      (alu_z)
  );

  // the step leaving phase four is the start of the next phase one
  assign boundary   = advance && (phase == ifp_pkg::IFP_PH_FOUR);
  // result lands at end of phase three so phase four can decide a skip
  assign alu_step   = advance && (phase == ifp_pkg::IFP_PH_THREE) &&
                      q.exec_valid && alu_en;
  assign low_wr_hit = reg_wr && (reg_addr == `IFP_LOW_ADDR);
  assign low_rd_hit = reg_rd && (reg_addr == `IFP_LOW_ADDR);

  always_comb begin
    d         = q;
    take_jump = 1'b0;
    flush     = 1'b0;
    base      = q.pc;
    d.fetch_rd  = 1'b0;
    d.cyc_start = 1'b0;
    // unmapped or idle reads answer zero
    d.rdata     = `IFP_BYTE_ZERO;
    if (low_rd_hit) begin
      d.rdata = q.pc[`IFP_LOW_MSB:0];
    end
    // a low byte write keeps the page and spoils the fetch in flight
    if (low_wr_hit) begin
      d.pc       = {q.pc[`IFP_PCH_MSB:`IFP_PCH_LSB], reg_wdata};
      d.low_pend = 1'b1;
    end
    if (alu_step) begin
      d.acc   = alu_res;
      d.carry = alu_c;
      d.zero  = alu_z;
    end
    if (boundary) begin
      case (q.slot)
        ifp_pkg::IFP_SLOT_EXEC: begin
          take_jump = ex_jump;
          flush     = ex_jump || ex_skip;
        end
        ifp_pkg::IFP_SLOT_DUMMY: begin
          take_jump = 1'b0;
          flush     = 1'b0;
        end
        default: begin
          take_jump = 1'b0;
          flush     = 1'b1;
        end
      endcase
      // a jump target wins over a same-cycle low byte write
      base         = take_jump ? ex_target : d.pc;
      d.fetch_addr = base;
      d.pc         = base + `IFP_PC_STEP;
      d.fetch_rd   = 1'b1;
      d.cyc_start  = 1'b1;
      if (flush || d.low_pend) begin
        // the prefetched word is dropped; a dummy cycle takes its slot
        d.slot       = ifp_pkg::IFP_SLOT_DUMMY;
        d.exec_valid = 1'b0;
        d.instr      = `IFP_INSTR_ZERO;
      end else begin
        // word fetched last cycle executes while the next is fetched
        d.slot       = ifp_pkg::IFP_SLOT_EXEC;
        d.exec_valid = 1'b1;
        d.instr      = pmem_data;
      end
      d.low_pend = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q.pc         <= `IFP_PC_RESET;
      q.fetch_addr <= `IFP_PC_RESET;
      q.fetch_rd   <= 1'b0;
      q.cyc_start  <= 1'b0;
      q.instr      <= `IFP_INSTR_ZERO;
      q.slot       <= ifp_pkg::IFP_SLOT_DUMMY;
      q.exec_valid <= 1'b0;
      // no word fetched yet: the first cycle must not run stale memory data
      q.low_pend   <= 1'b1;
      q.acc        <= `IFP_BYTE_ZERO;
      q.carry      <= 1'b0;
      q.zero       <= 1'b0;
      q.rdata      <= `IFP_BYTE_ZERO;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata          = q.rdata;
  assign pmem_addr          = q.fetch_addr;
  assign pmem_rd            = q.fetch_rd;
  assign instruction_phases = phase;
  assign cycle_start        = q.cyc_start;
  assign exec_instr         = q.instr;
  assign exec_valid         = q.exec_valid;
  assign acc_value          = q.acc;
  assign alu_carry          = q.carry;
  assign alu_zero           = q.zero;
  assign pc_value           = q.pc;

endmodule : ifp_core

// ---- ifp_defines.svh ----
`ifndef IFP_DEFINES_SVH
`define IFP_DEFINES_SVH

// widths
`define IFP_PC_W        11
`define IFP_LOW_W       8
`define IFP_PCH_MSB     10
`define IFP_PCH_LSB     8
`define IFP_LOW_MSB     7
`define IFP_INSTR_W     16
`define IFP_RADDR_W     8
`define IFP_ALU_W       8

// register map
`define IFP_LOW_ADDR    8'h00

// reset and constant values
`define IFP_PC_RESET    11'h000
`define IFP_PC_STEP     11'h001
`define IFP_BYTE_ZERO   8'h00
`define IFP_BYTE_ONE    8'h01
`define IFP_INSTR_ZERO  16'h0000

// phase codes, one-hot
`define IFP_PH1         4'h1
`define IFP_PH2         4'h2
`define IFP_PH3         4'h4
`define IFP_PH4         4'h8

// execution slot codes, one-hot
`define IFP_SLOT_EXEC   2'h1
`define IFP_SLOT_DUMMY  2'h2

// oscillator select
`define IFP_OSC_FAST    1'b0

// alu operations
`define IFP_OP_ADD      4'h0
`define IFP_OP_SUB      4'h1
`define IFP_OP_AND      4'h2
`define IFP_OP_OR       4'h3
`define IFP_OP_XOR      4'h4
`define IFP_OP_CPL      4'h5
`define IFP_OP_RR       4'h6
`define IFP_OP_RL       4'h7
`define IFP_OP_INC      4'h8
`define IFP_OP_DEC      4'h9
`define IFP_OP_MOV      4'ha
`define IFP_OP_NOP      4'hf

`endif

// ---- ifp_pkg.sv ----
`include "ifp_defines.svh"

package ifp_pkg;

  typedef enum logic [3:0] {
    IFP_PH_ONE   = `IFP_PH1,
    IFP_PH_TWO   = `IFP_PH2,
    IFP_PH_THREE = `IFP_PH3,
    IFP_PH_FOUR  = `IFP_PH4
  } ifp_phase_e;

  typedef enum logic [1:0] {
    IFP_SLOT_EXEC  = `IFP_SLOT_EXEC,
    IFP_SLOT_DUMMY = `IFP_SLOT_DUMMY
  } ifp_slot_e;

  typedef enum logic [3:0] {
    IFP_ALU_ADD = `IFP_OP_ADD,
    IFP_ALU_SUB = `IFP_OP_SUB,
    IFP_ALU_AND = `IFP_OP_AND,
    IFP_ALU_OR  = `IFP_OP_OR,
    IFP_ALU_XOR = `IFP_OP_XOR,
    IFP_ALU_CPL = `IFP_OP_CPL,
    IFP_ALU_RR  = `IFP_OP_RR,
    IFP_ALU_RL  = `IFP_OP_RL,
    IFP_ALU_INC = `IFP_OP_INC,
    IFP_ALU_DEC = `IFP_OP_DEC,
    IFP_ALU_MOV = `IFP_OP_MOV,
    IFP_ALU_NOP = `IFP_OP_NOP
  } ifp_alu_op_e;

  typedef struct packed {
    ifp_phase_e phase;
  } ifp_phase_s;

  typedef struct packed {
    logic [`IFP_PC_W-1:0]    pc;
    logic [`IFP_PC_W-1:0]    fetch_addr;
    logic                    fetch_rd;
    logic                    cyc_start;
    logic [`IFP_INSTR_W-1:0] instr;
    ifp_slot_e               slot;
    logic                    exec_valid;
    logic                    low_pend;
    logic [`IFP_ALU_W-1:0]   acc;
    logic                    carry;
    logic                    zero;
    logic [`IFP_LOW_W-1:0]   rdata;
  } ifp_core_s;

endpackage : ifp_pkg

// ---- ifp_phase_gen.sv ----
`timescale 1ns/1ps
`include "ifp_defines.svh"

module ifp_phase_gen (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              osc_sel,
  input  wire logic              fast_internal_oscillator_tick,
  input  wire logic              slow_internal_oscillator_tick,
  output ifp_pkg::ifp_phase_e    phase,
  output logic                   advance
);

  ifp_pkg::ifp_phase_s q, d;

  // system clock edge taken from the selected oscillator
  always_comb begin
    advance = (osc_sel == `IFP_OSC_FAST) ? fast_internal_oscillator_tick
                                          : slow_internal_oscillator_tick;
  end

  // exactly one phase active at a time; four of them make a cycle
  always_comb begin
    d = q;
    if (advance) begin
      case (q.phase)
        ifp_pkg::IFP_PH_ONE:   d.phase = ifp_pkg::IFP_PH_TWO;
        ifp_pkg::IFP_PH_TWO:   d.phase = ifp_pkg::IFP_PH_THREE;
        ifp_pkg::IFP_PH_THREE: d.phase = ifp_pkg::IFP_PH_FOUR;
        ifp_pkg::IFP_PH_FOUR:  d.phase = ifp_pkg::IFP_PH_ONE;
        default:               d.phase = ifp_pkg::IFP_PH_FOUR;
      endcase
    end
  end

  // resets to phase four so the first tick opens a fresh cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q.phase <= ifp_pkg::IFP_PH_FOUR;
    end else begin
      q <= d;
    end
  end

  assign phase = q.phase;

endmodule : ifp_phase_gen

// ---- ifp_alu.sv ----
`timescale 1ns/1ps
`include "ifp_defines.svh"

module ifp_alu (
  input  ifp_pkg::ifp_alu_op_e      op,
  input  wire logic [`IFP_ALU_W-1:0] acc,
  input  wire logic [`IFP_ALU_W-1:0] operand,
  input  wire logic                  carry_in,
  output logic      [`IFP_ALU_W-1:0] result,
  output logic                       carry_out,
  output logic                       zero
);

  logic [`IFP_ALU_W:0] wide;

  // 8-bit operations on the accumulator; carry changes only for add and subtract, every other op holds it
  always_comb begin
    wide      = {1'b0, acc};
    carry_out = carry_in;
    case (op)
      ifp_pkg::IFP_ALU_ADD: begin
        wide      = {1'b0, acc} + {1'b0, operand};
        carry_out = wide[`IFP_ALU_W];
      end
      ifp_pkg::IFP_ALU_SUB: begin
        wide      = {1'b0, acc} - {1'b0, operand};
        carry_out = ~wide[`IFP_ALU_W];
      end
      ifp_pkg::IFP_ALU_AND: wide = {1'b0, acc & operand};
      ifp_pkg::IFP_ALU_OR:  wide = {1'b0, acc | operand};
      ifp_pkg::IFP_ALU_XOR: wide = {1'b0, acc ^ operand};
      ifp_pkg::IFP_ALU_CPL: wide = {1'b0, ~acc};
      ifp_pkg::IFP_ALU_RR:  wide = {1'b0, acc[0], acc[`IFP_ALU_W-1:1]};
      ifp_pkg::IFP_ALU_RL:  wide = {1'b0, acc[`IFP_ALU_W-2:0], acc[`IFP_ALU_W-1]};
      ifp_pkg::IFP_ALU_INC: wide = {1'b0, acc} + {1'b0, `IFP_BYTE_ONE};
      ifp_pkg::IFP_ALU_DEC: wide = {1'b0, acc} - {1'b0, `IFP_BYTE_ONE};
      ifp_pkg::IFP_ALU_MOV: wide = {1'b0, operand};
      default:              wide = {1'b0, acc};
    endcase
    result = wide[`IFP_ALU_W-1:0];
    zero   = (result == `IFP_BYTE_ZERO);
  end

endmodule : ifp_alu

// ---- ifp_pmem_model.sv ----
`timescale 1ns/1ps
module ifp_pmem_model (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic [10:0]     pmem_addr,
  input  wire logic            pmem_rd,
  output logic      [15:0]     pmem_data,
  input  wire logic [15:0]     exec_instr,
  input  wire logic            exec_valid,
  output ifp_pkg::ifp_alu_op_e alu_op,
  output logic                 alu_en,
  output logic      [7:0]      alu_operand,
  output logic                 ex_jump,
  output logic      [10:0]     ex_target,
  output logic                 ex_skip
);
  // word format: bit15 jump, bit14 skip, bit13 alu, low bits target or op/operand
  logic [15:0] mem [0:2047];
  initial foreach (mem[i]) mem[i] = {5'h00, 11'(i)};
  // synchronous rom: the word stays put until the next fetch pulse
  always_ff @(posedge clk) begin
    if (sys_rst) pmem_data <= 16'h0000;
    else if (pmem_rd) pmem_data <= mem[pmem_addr];
  end
  assign ex_jump = exec_valid & exec_instr[15];
  assign ex_target = exec_instr[10:0];
  assign ex_skip = exec_valid & exec_instr[14];
  assign alu_en = exec_valid & exec_instr[13];
  assign alu_op = ifp_pkg::ifp_alu_op_e'(exec_instr[11:8]);
  assign alu_operand = exec_instr[7:0];
endmodule : ifp_pmem_model

// ---- ifp_monitor.sv ----
`timescale 1ns/1ps
module ifp_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        osc_sel,
  input wire logic        fast_internal_oscillator_tick,
  input wire logic        slow_internal_oscillator_tick,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [10:0] pmem_addr,
  input wire logic        pmem_rd,
  input wire logic [3:0]  instruction_phases,
  input wire logic        cycle_start,
  input wire logic        exec_valid,
  input wire logic        ex_jump,
  input wire logic [10:0] ex_target,
  input wire logic        ex_skip,
  input wire logic [10:0] pc_value
);
  logic tk, bnd, wr0;
  assign tk = osc_sel ? slow_internal_oscillator_tick : fast_internal_oscillator_tick;
  assign bnd = tk && instruction_phases == 4'h8;
  assign wr0 = reg_wr && reg_addr == 8'h00;
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_phase_hot: assert property ($onehot(instruction_phases))
    else $error("phase not one-hot");
  chk_phase_wrap: assert property (bnd |=> instruction_phases == 4'h1 && cycle_start)
    else $error("no wrap to phase one");
  chk_phase_hold: assert property (!tk |=> $stable(instruction_phases))
    else $error("phase moved without tick");
  chk_pc_next: assert property (cycle_start |-> pc_value == pmem_addr + 11'h001)
    else $error("counter not fetch plus one");
  chk_fetch_pulse: assert property (
    pmem_rd == cycle_start && (!pmem_rd || instruction_phases == 4'h1))
    else $error("fetch pulse misplaced");
  chk_jump_load: assert property (
    bnd && exec_valid && ex_jump |=> pmem_addr == $past(ex_target) && !exec_valid)
    else $error("jump target not loaded");
  chk_skip_flush: assert property (
    bnd && exec_valid && ex_skip && !ex_jump && !wr0 |=> !exec_valid ##0
    pmem_addr == $past(pc_value))
    else $error("skip not flushed");
  chk_low_read: assert property (
    reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(pc_value[7:0]) ##1
    ($past(reg_rd) || reg_rdata == 8'h00))
    else $error("low byte read wrong");
  chk_low_write: assert property (
    wr0 && !bnd |=> pc_value == {$past(pc_value[10:8]), $past(reg_wdata)})
    else $error("low byte write wrong");
  cov_jump: cover property (bnd && exec_valid && ex_jump);
  cov_skip: cover property (bnd && exec_valid && ex_skip);
  cov_slow: cover property (osc_sel && cycle_start);
endmodule : ifp_monitor
bind ifp_core ifp_monitor mon_u (.*);

// ---- test_instruction_fetch_pipeline.sv ----
`timescale 1ns/1ps
module test_instruction_fetch_pipeline;
  logic clk, sys_rst, osc_sel, reg_wr, reg_rd, pmem_rd, cycle_start, exec_valid;
  logic fast_internal_oscillator_tick, slow_internal_oscillator_tick;
  logic alu_en, ex_jump, ex_skip, alu_carry, alu_zero;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, alu_operand, acc_value;
  logic [10:0] pmem_addr, ex_target, pc_value, prev;
  logic [15:0] pmem_data, exec_instr;
  logic [3:0]  instruction_phases;
  logic [1:0]  sdiv;
  ifp_pkg::ifp_alu_op_e alu_op;
  int err_total, samples_checked, cyc, n;
  logic [10:0] ea [10] = '{11'h001, 11'h002, 11'h003, 11'h004, 11'h5a3,
                           11'h5a4, 11'h5a5, 11'h5a6, 11'h5a7, 11'h5a8};
  logic [9:0]  ev = 10'h36f;
  ifp_core dut_u (.*);
  ifp_pmem_model pm_u (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // slow tick one clock in three, free running
  always @(posedge clk) begin
    sdiv <= (sdiv == 2'h2) ? 2'h0 : sdiv + 2'h1;
    slow_internal_oscillator_tick <= (sdiv == 2'h1);
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out;
    end
  end
  task automatic close_out;
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic wait_start;
    n = 0;
    while (cycle_start !== 1'b1 && n < 64) begin
      step;
      n++;
    end
  endtask : wait_start
  task automatic next_cyc;
    step;
    wait_start;
  endtask : next_cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, v);
    step;
    chk(reg_rdata, 8'h00);
  endtask : rd
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(pc_value, 11'h000);
    chk(pmem_addr, 11'h000);
    chk(instruction_phases, 4'h8);
    // first cycle fetches the reset location and has nothing to execute yet
    wait_start;
    chk(pmem_addr, 11'h000);
    chk(pc_value, 11'h001);
    chk(exec_valid, 1'b0);
  endtask : do_reset
  initial begin
    {sys_rst, fast_internal_oscillator_tick} = 2'h3;
    {osc_sel, slow_internal_oscillator_tick, reg_wr, reg_rd, sdiv} = 6'h00;
    {reg_addr, reg_wdata, err_total, samples_checked, cyc, prev} = '0;
    do_reset;
    // loaded after time zero so the model's own fill cannot overwrite it
    pm_u.mem[11'h003] = 16'h85a3;
    pm_u.mem[11'h5a4] = 16'h4000;
    pm_u.mem[11'h5a6] = 16'h2012;
    pm_u.mem[11'h5a7] = 16'h2801;
    // sequential run, then a jump, then a met skip
    for (int k = 0; k < 10; k++) begin
      next_cyc;
      chk(pmem_addr, ea[k]);
      chk(pc_value, ea[k] + 11'h001);
      chk(exec_valid, ev[k]);
      chk(exec_instr, ev[k] ? pm_u.mem[prev] : 16'h0000);
      for (int p = 1; p < 4 && k == 0; p++) begin
        step;
        chk(instruction_phases, 4'h1 << p);
      end
      prev = ea[k];
    end
    next_cyc;
    chk(acc_value, 8'h13);
    chk(alu_carry, 1'b0);
    chk(alu_zero, 1'b0);
    step;
    wr(8'h00, 8'h40);
    next_cyc;
    chk(pmem_addr, 11'h540);
    chk(exec_valid, 1'b0);
    next_cyc;
    chk(exec_valid, 1'b1);
    chk(exec_instr, pm_u.mem[11'h540]);
    chk(pmem_addr, 11'h541);
    rd(8'h00, 8'h42);
    rd(8'h01, 8'h00);
    wr(8'h01, 8'h77);
    next_cyc;
    chk(pmem_addr, 11'h544);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      osc_sel <= m[0];
      next_cyc;
      next_cyc;
      chk(16'(n + 1), m[0] ? 16'h000c : 16'h0004);
    end
    @(posedge clk);
    do_reset;
    close_out;
  end
endmodule : test_instruction_fetch_pipeline
